// file: rtl/spread_modem_cfg.sv
// apb configuration front end and symbol timer of the spread spectrum modem
`default_nettype none
module spread_modem_cfg (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // apb slave
  input  wire logic [11:0] i_paddr,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // modem control
  input  wire logic        i_modem_run,
  output logic             o_spread_modem_en,
  output logic             o_fsk_modem_en,
  output logic             o_zero_if,
  output logic             o_digital_mix,
  output logic      [11:0] o_chips_per_symbol,
  output logic      [3:0]  o_bits_per_symbol,
  output logic      [9:0]  o_bw_dsb_khz,
  output logic      [19:0] o_symbol_rate,
  output logic      [3:0]  o_cr_denom,
  output logic             o_symbol_tick,
  // header
  output logic             o_header_present,
  output logic      [11:0] o_header_word
);
  logic [1:0]  frame_kind_q;
  logic [3:0]  sf_q;
  logic [3:0]  bw_q;
  logic [2:0]  cr_q;
  logic        low_rate_opt_q;
  logic        hdr_expl_q;
  logic        hdr_crc_q;
  logic [7:0]  hdr_len_q;
  logic [31:0] rdata_q;
  logic        err_q;
  logic [11:0] chips_d;
  logic [3:0]  bits_d;
  logic [9:0]  bwk_d;
  logic [19:0] rate_d;
  logic [15:0] chip_cyc_d;
  logic        zif_d;
  logic [3:0]  den_d;
  logic [15:0] chip_cnt_q;
  logic [11:0] chip_idx_q;
  logic [15:0] chip_cyc_q;
  logic [31:0] mod_word;
  logic [31:0] hdr_word;
  logic [31:0] frame_word;
  logic [31:0] mod_new;
  logic [31:0] hdr_new;
  logic [31:0] frame_new;
  logic        setup;
  logic        access;
  logic        do_write;
  logic        run;

  // byte-lane merge of a write into a register word
  function automatic logic [31:0] wmerge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction

  // legal modulation word: sf, bandwidth and coding rate in range
  function automatic logic mod_ok(input logic [31:0] w);
    logic [3:0] sf;
    logic [3:0] bw;
    logic [2:0] cr;
    sf = w[ssm_cfg_pkg::MOD_SF_LSB +: 4];
    bw = w[ssm_cfg_pkg::MOD_BW_LSB +: 4];
    cr = w[ssm_cfg_pkg::MOD_CR_LSB +: 3];
    return (sf >= ssm_cfg_pkg::SF_MIN) && (sf <= ssm_cfg_pkg::SF_MAX) &&
           (bw >= ssm_cfg_pkg::BW_C125) && (bw <= ssm_cfg_pkg::BW_C500) &&
           (cr >= ssm_cfg_pkg::CR_MIN) && (cr <= ssm_cfg_pkg::CR_MAX);
  endfunction

  function automatic logic frame_ok(input logic [31:0] w);
    return (w[1:0] == ssm_cfg_pkg::FRAME_FSK) || (w[1:0] == ssm_cfg_pkg::FRAME_SPREAD);
  endfunction

  chirp_param_decode u_decode (
    .i_spreading_factor     (sf_q),
    .i_chirp_bandwidth_code (bw_q),
    .i_coding_rate          (cr_q),
    .i_low_rate_optimize    (low_rate_opt_q),
    .o_chips_per_symbol     (chips_d),
    .o_bits_per_symbol      (bits_d),
    .o_bw_dsb_khz           (bwk_d),
    .o_symbol_rate          (rate_d),
    .o_chip_cycles          (chip_cyc_d),
    .o_zero_if              (zif_d),
    .o_cr_denom             (den_d)
  );

  assign setup  = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  // zero wait states: decode happens in setup, answer in first access cycle
  assign o_pready  = access;
  assign o_prdata  = rdata_q;
  assign o_pslverr = err_q && access;
  assign do_write  = access && i_pwrite && !err_q;

  assign frame_word = {30'h0000_0000, frame_kind_q};
  assign mod_word = {19'h0_0000, low_rate_opt_q, 1'b0, cr_q, bw_q, sf_q};
  assign hdr_word = {16'h0000, hdr_len_q, 6'h00, hdr_crc_q, hdr_expl_q};
  assign mod_new   = wmerge(mod_word, i_pwdata, i_pstrb);
  assign hdr_new   = wmerge(hdr_word, i_pwdata, i_pstrb);
  assign frame_new = wmerge(frame_word, i_pwdata, i_pstrb);

  // read data and error are captured in setup; request is held stable after
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else if (setup) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
      if (i_paddr == ssm_cfg_pkg::ADDR_FRAME) begin
        rdata_q <= frame_word;
        err_q   <= i_pwrite && !frame_ok(frame_new);
      end else if (i_paddr == ssm_cfg_pkg::ADDR_MOD) begin
        rdata_q <= mod_word;
        // refused while fsk frame kind is selected
        err_q   <= i_pwrite && ((frame_kind_q != ssm_cfg_pkg::FRAME_SPREAD) ||
                                !mod_ok(mod_new));
      end else if (i_paddr == ssm_cfg_pkg::ADDR_HDR) begin
        rdata_q <= hdr_word;
      end else if (i_paddr == ssm_cfg_pkg::ADDR_STAT) begin
        rdata_q[ssm_cfg_pkg::ST_CHIPS_LSB +: 12] <= o_chips_per_symbol;
        rdata_q[ssm_cfg_pkg::ST_BITS_LSB +: 4]   <= o_bits_per_symbol;
        rdata_q[ssm_cfg_pkg::ST_DEN_LSB +: 4]    <= o_cr_denom;
        rdata_q[ssm_cfg_pkg::ST_ZIF_BIT]         <= o_zero_if;
        rdata_q[ssm_cfg_pkg::ST_BW_LSB +: 10]    <= o_bw_dsb_khz;
        err_q <= i_pwrite;
      end else if (i_paddr == ssm_cfg_pkg::ADDR_RATE) begin
        rdata_q <= {12'h000, o_symbol_rate};
        err_q   <= i_pwrite;
      end else if (i_paddr == ssm_cfg_pkg::ADDR_HWORD) begin
        rdata_q <= {19'h0_0000, o_header_present, o_header_word};
        err_q   <= i_pwrite;
      end else begin
        err_q <= 1'b1;
      end
    end
  end

  // frame kind register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_kind_q <= ssm_cfg_pkg::FRAME_FSK;
    end else if (do_write && i_paddr == ssm_cfg_pkg::ADDR_FRAME) begin
      frame_kind_q <= frame_new[1:0];
    end
  end

  // modulation parameters, kept while fsk is selected
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sf_q   <= ssm_cfg_pkg::SF_RST;
      bw_q   <= ssm_cfg_pkg::BW_C125;
      cr_q   <= ssm_cfg_pkg::CR_MIN;
      low_rate_opt_q <= 1'b0;
    end else if (do_write && i_paddr == ssm_cfg_pkg::ADDR_MOD) begin
      sf_q   <= mod_new[ssm_cfg_pkg::MOD_SF_LSB +: 4];
      bw_q   <= mod_new[ssm_cfg_pkg::MOD_BW_LSB +: 4];
      cr_q   <= mod_new[ssm_cfg_pkg::MOD_CR_LSB +: 3];
      low_rate_opt_q <= mod_new[ssm_cfg_pkg::MOD_LOWRATE_BIT];
    end
  end

  // header config; no sf restriction on either header mode
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hdr_expl_q <= 1'b1;
      hdr_crc_q  <= 1'b0;
      hdr_len_q  <= ssm_cfg_pkg::LEN_RST;
    end else if (do_write && i_paddr == ssm_cfg_pkg::ADDR_HDR) begin
      hdr_expl_q <= hdr_new[ssm_cfg_pkg::HDR_EXPL_BIT];
      hdr_crc_q  <= hdr_new[ssm_cfg_pkg::HDR_CRC_BIT];
      hdr_len_q  <= hdr_new[ssm_cfg_pkg::HDR_LEN_LSB +: 8];
    end
  end

  // modem engine and frame format follow the frame kind
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_spread_modem_en <= 1'b0;
      o_fsk_modem_en    <= 1'b1;
    end else begin
      o_spread_modem_en <= (frame_kind_q == ssm_cfg_pkg::FRAME_SPREAD);
      o_fsk_modem_en    <= (frame_kind_q == ssm_cfg_pkg::FRAME_FSK);
    end
  end

  // registered decode outputs
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_chips_per_symbol <= 12'h000;
      o_bits_per_symbol  <= 4'h0;
      o_bw_dsb_khz       <= 10'h000;
      o_symbol_rate      <= 20'h0_0000;
      o_cr_denom         <= 4'h0;
      o_zero_if          <= 1'b0;
      o_digital_mix      <= 1'b0;
      chip_cyc_q         <= ssm_cfg_pkg::CHIP_CYC_125;
    end else begin
      o_chips_per_symbol <= chips_d;
      o_bits_per_symbol  <= bits_d;
      o_bw_dsb_khz       <= bwk_d;
      o_symbol_rate      <= rate_d;
      o_cr_denom         <= den_d;
      o_zero_if          <= zif_d;
      o_digital_mix      <= !zif_d;
      chip_cyc_q         <= chip_cyc_d;
    end
  end

  // header word carries the transmit coding rate only in explicit mode
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_header_present <= 1'b0;
      o_header_word    <= 12'h000;
    end else begin
      o_header_present <= hdr_expl_q && o_spread_modem_en;
      o_header_word    <= 12'h000;
      if (hdr_expl_q) begin
        o_header_word[ssm_cfg_pkg::HW_LEN_LSB +: 8] <= hdr_len_q;
        o_header_word[ssm_cfg_pkg::HW_CR_LSB +: 3]  <= cr_q;
        o_header_word[ssm_cfg_pkg::HW_CRC_BIT]      <= hdr_crc_q;
      end
    end
  end

  // symbol timer: one chip per 1/bw, 2^sf chips per symbol
  assign run = o_spread_modem_en && i_modem_run;

  // >= compare so a parameter change mid-symbol cannot overrun the count
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chip_cnt_q    <= 16'h0000;
      chip_idx_q    <= 12'h000;
      o_symbol_tick <= 1'b0;
    end else if (!run) begin
      chip_cnt_q    <= 16'h0000;
      chip_idx_q    <= 12'h000;
      o_symbol_tick <= 1'b0;
    end else begin
      o_symbol_tick <= 1'b0;
      if (chip_cnt_q >= 16'(chip_cyc_q - 16'h0001)) begin
        chip_cnt_q <= 16'h0000;
        if (chip_idx_q >= 12'(o_chips_per_symbol - ssm_cfg_pkg::CHIPS_ONE)) begin
          chip_idx_q    <= 12'h000;
          o_symbol_tick <= 1'b1;
        end else begin
          chip_idx_q <= 12'(chip_idx_q + 12'h001);
        end
      end else begin
        chip_cnt_q <= 16'(chip_cnt_q + 16'h0001);
      end
    end
  end

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  a_fsk_mod_kept: assert property (
    (access && i_pwrite && i_paddr == ssm_cfg_pkg::ADDR_MOD &&
     frame_kind_q == ssm_cfg_pkg::FRAME_FSK) |=> ($stable(sf_q) && $stable(bw_q) &&
     $stable(cr_q) && $stable(low_rate_opt_q)))
    else $error("modulation changed under fsk frame kind");

  a_fsk_mod_err: assert property (
    (setup && i_pwrite && i_paddr == ssm_cfg_pkg::ADDR_MOD &&
     frame_kind_q == ssm_cfg_pkg::FRAME_FSK) ##1 access |-> o_pslverr)
    else $error("fsk modulation write not flagged");

  a_modem_follow: assert property (
    ##1 (o_spread_modem_en == ($past(frame_kind_q) == ssm_cfg_pkg::FRAME_SPREAD)) &&
    (o_fsk_modem_en == ($past(frame_kind_q) == ssm_cfg_pkg::FRAME_FSK)))
    else $error("modem engine does not follow frame kind");

  a_query_kind: assert property (
    (access && !i_pwrite && i_paddr == ssm_cfg_pkg::ADDR_FRAME) |->
    (o_prdata[1:0] == frame_kind_q))
    else $error("frame kind query wrong");

  // decode outputs sit at zero through the release edge, so start one cycle in
  a_chips_pow: assert property (
    i_rst_n |=> (o_chips_per_symbol == (ssm_cfg_pkg::CHIPS_ONE << $past(sf_q))))
    else $error("chips per symbol wrong");

  a_sf_range: assert property (
    (sf_q >= ssm_cfg_pkg::SF_MIN) && (sf_q <= ssm_cfg_pkg::SF_MAX))
    else $error("spreading factor out of range");

  a_lowrate_bits: assert property (
    i_rst_n |=> (o_bits_per_symbol == ($past(low_rate_opt_q) ?
                 4'($past(sf_q) - ssm_cfg_pkg::LOWRATE_DROP) : $past(sf_q))))
    else $error("bits per symbol wrong");

  a_conv_mode: assert property (
    i_rst_n |=> (o_zero_if == ($past(bw_q) == ssm_cfg_pkg::BW_C500)) &&
                (o_digital_mix != o_zero_if))
    else $error("conversion mode wrong for bandwidth");

  a_cr_denom: assert property (
    i_rst_n |=> (o_cr_denom == 4'(ssm_cfg_pkg::CR_BASE + $past(cr_q))))
    else $error("coding rate denominator wrong");

  a_tick_gap: assert property (
    o_symbol_tick |=> !o_symbol_tick [*8])
    else $error("symbol ticks too close");

  a_hdr_implicit: assert property (
    !hdr_expl_q |=> !o_header_present && (o_header_word == 12'h000))
    else $error("header produced in implicit mode");

  a_hdr_cr: assert property (
    (i_rst_n && hdr_expl_q) |=>
    (o_header_word[ssm_cfg_pkg::HW_CR_LSB +: 3] == $past(cr_q)))
    else $error("header coding rate wrong");

  a_kind_refused: assert property (
    (access && i_pwrite && i_paddr == ssm_cfg_pkg::ADDR_FRAME && !frame_ok(frame_new)) |->
    o_pslverr)
    else $error("illegal frame kind write not flagged");

  c_mod_accept: cover property (do_write && i_paddr == ssm_cfg_pkg::ADDR_MOD);
  c_mod_refuse: cover property (o_pslverr && i_paddr == ssm_cfg_pkg::ADDR_MOD);
  c_sym_tick:   cover property (o_symbol_tick);
  c_query:      cover property (access && !i_pwrite && i_paddr == ssm_cfg_pkg::ADDR_FRAME);
  c_zero_if:    cover property (o_zero_if && o_spread_modem_en);
endmodule
`default_nettype wire

// file: rtl/ssm_cfg_pkg.sv
// constants and encodings for the chirp spread spectrum modem configuration block
`default_nettype none
package ssm_cfg_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_FRAME = 12'h000;
  localparam logic [11:0] ADDR_MOD   = 12'h004;
  localparam logic [11:0] ADDR_HDR   = 12'h008;
  localparam logic [11:0] ADDR_STAT  = 12'h00C;
  localparam logic [11:0] ADDR_RATE  = 12'h010;
  localparam logic [11:0] ADDR_HWORD = 12'h014;
  // frame kind codes
  localparam logic [1:0] FRAME_FSK    = 2'h0;
  localparam logic [1:0] FRAME_SPREAD = 2'h1;
  // modulation word fields
  localparam int MOD_SF_LSB   = 0;
  localparam int MOD_BW_LSB   = 4;
  localparam int MOD_CR_LSB   = 8;
  localparam int MOD_LOWRATE_BIT = 12;
  // header config word fields
  localparam int HDR_EXPL_BIT = 0;
  localparam int HDR_CRC_BIT  = 1;
  localparam int HDR_LEN_LSB  = 8;
  // status word fields
  localparam int ST_CHIPS_LSB = 0;
  localparam int ST_BITS_LSB  = 12;
  localparam int ST_DEN_LSB   = 16;
  localparam int ST_ZIF_BIT   = 20;
  localparam int ST_BW_LSB    = 21;
  // header word fields
  localparam int HW_LEN_LSB = 0;
  localparam int HW_CR_LSB  = 8;
  localparam int HW_CRC_BIT = 11;
  // legal ranges and reset values
  localparam logic [3:0] SF_MIN   = 4'h5;
  localparam logic [3:0] SF_MAX   = 4'hB;
  localparam logic [3:0] SF_RST   = 4'h7;
  localparam logic [3:0] BW_C125  = 4'h7;
  localparam logic [3:0] BW_C250  = 4'h8;
  localparam logic [3:0] BW_C500  = 4'h9;
  localparam logic [2:0] CR_MIN   = 3'h1;
  localparam logic [2:0] CR_MAX   = 3'h4;
  localparam logic [3:0] CR_BASE  = 4'h4;
  localparam logic [3:0] LOWRATE_DROP = 4'h2;
  localparam logic [7:0] LEN_RST  = 8'h00;
  // bandwidths, double sideband
  localparam logic [9:0]  BW_KHZ_125 = 10'h07D;
  localparam logic [9:0]  BW_KHZ_250 = 10'h0FA;
  localparam logic [9:0]  BW_KHZ_500 = 10'h1F4;
  localparam logic [19:0] BW_HZ_125  = 20'h1E848;
  localparam logic [19:0] BW_HZ_250  = 20'h3D090;
  localparam logic [19:0] BW_HZ_500  = 20'h7A120;
  // clock rate and cycles per chip
  localparam int CLK_HZ = 32'h0773_5940;
  localparam logic [15:0] CHIP_CYC_125 = 16'(CLK_HZ / BW_HZ_125);
  localparam logic [15:0] CHIP_CYC_250 = 16'(CLK_HZ / BW_HZ_250);
  localparam logic [15:0] CHIP_CYC_500 = 16'(CLK_HZ / BW_HZ_500);
  localparam logic [11:0] CHIPS_ONE = 12'h001;
endpackage
`default_nettype wire

// file: rtl/chirp_param_decode.sv
// combinational decode of spread spectrum modulation parameters
`default_nettype none
module chirp_param_decode (
  // programmed parameters
  input  wire logic [3:0]  i_spreading_factor,
  input  wire logic [3:0]  i_chirp_bandwidth_code,
  input  wire logic [2:0]  i_coding_rate,
  input  wire logic        i_low_rate_optimize,
  // decoded values
  output logic      [11:0] o_chips_per_symbol,
  output logic      [3:0]  o_bits_per_symbol,
  output logic      [9:0]  o_bw_dsb_khz,
  output logic      [19:0] o_symbol_rate,
  output logic      [15:0] o_chip_cycles,
  output logic             o_zero_if,
  output logic      [3:0]  o_cr_denom
);
  logic [19:0] bw_hz;

  always_comb begin
    // bandwidth value is the full double sideband width
    case (i_chirp_bandwidth_code)
      ssm_cfg_pkg::BW_C250: begin
        o_bw_dsb_khz  = ssm_cfg_pkg::BW_KHZ_250;
        bw_hz         = ssm_cfg_pkg::BW_HZ_250;
        o_chip_cycles = ssm_cfg_pkg::CHIP_CYC_250;
      end
      ssm_cfg_pkg::BW_C500: begin
        o_bw_dsb_khz  = ssm_cfg_pkg::BW_KHZ_500;
        bw_hz         = ssm_cfg_pkg::BW_HZ_500;
        o_chip_cycles = ssm_cfg_pkg::CHIP_CYC_500;
      end
      default: begin
        o_bw_dsb_khz  = ssm_cfg_pkg::BW_KHZ_125;
        bw_hz         = ssm_cfg_pkg::BW_HZ_125;
        o_chip_cycles = ssm_cfg_pkg::CHIP_CYC_125;
      end
    endcase
  end

  // only the widest setting skips the digital second mix
  assign o_zero_if = (i_chirp_bandwidth_code == ssm_cfg_pkg::BW_C500);
  assign o_chips_per_symbol = ssm_cfg_pkg::CHIPS_ONE << i_spreading_factor;
  assign o_symbol_rate = bw_hz >> i_spreading_factor;
  assign o_bits_per_symbol = i_low_rate_optimize ?
                             4'(i_spreading_factor - ssm_cfg_pkg::LOWRATE_DROP) :
                             i_spreading_factor;
  assign o_cr_denom = ssm_cfg_pkg::CR_BASE + {1'b0, i_coding_rate};
endmodule
`default_nettype wire

// file: verification/host_cfg_master.sv
// apb host model issuing modem configuration transfers
`default_nettype none
module host_cfg_master (
  // clock
  input  wire logic        i_ref_clk,
  // apb master side
  output logic      [11:0] o_paddr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic      [31:0] o_pwdata,
  output logic      [3:0]  o_pstrb,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic timed_out;
  initial begin
    o_paddr   = 12'h000;
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_pwdata  = 32'h0000_0000;
    o_pstrb   = 4'h0;
    timed_out = 1'b0;
  end
  // callers pick frame kind first, modulation only after it
  // preamble, low rate optimize and link-wide spreading are caller settings
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                      input logic [3:0] strb, output logic [31:0] rdata, output logic err);
    int n;
    @(posedge i_ref_clk);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite  <= wr;
    o_paddr   <= addr;
    o_pwdata  <= data;
    o_pstrb   <= strb;
    @(posedge i_ref_clk);
    o_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 64);
    timed_out = (i_pready !== 1'b1);
    rdata = i_prdata;
    err   = i_pslverr;
    // released address and data lines must not keep showing the old request
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    o_paddr   <= ~addr;
    o_pwdata  <= ~data;
  endtask
endmodule
`default_nettype wire

// file: verification/spread_spectrum_modem_config_tb.sv
// self-checking bench for the spread spectrum modem configuration front end
`default_nettype none
module spread_spectrum_modem_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0]  spr;
    logic [3:0]  bwc;
    logic [2:0]  cdr;
    logic        lro;
    logic [11:0] chips;
    logic [3:0]  bits;
    logic [9:0]  khz;
    logic [19:0] rate;
    logic [3:0]  den;
  } row_type;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, modem_run;
  logic        spread_en, fsk_en, zero_if, digital_mix, tick, hdr_present, er;
  logic [11:0] paddr, chips, hdr_word;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, bits, den;
  logic [9:0]  bw_khz;
  logic [19:0] sym_rate;
  int          mismatches, checks_done, n, per;
  row_type     rows [8];
  logic [31:0] bad [6];
  host_cfg_master host (.i_ref_clk(ref_clk), .o_paddr(paddr), .o_psel(psel),
    .o_penable(penable), .o_pwrite(pwrite), .o_pwdata(pwdata), .o_pstrb(pstrb),
    .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));
  spread_modem_cfg dut (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_paddr(paddr),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_modem_run(modem_run), .o_spread_modem_en(spread_en), .o_fsk_modem_en(fsk_en),
    .o_zero_if(zero_if), .o_digital_mix(digital_mix), .o_chips_per_symbol(chips),
    .o_bits_per_symbol(bits), .o_bw_dsb_khz(bw_khz), .o_symbol_rate(sym_rate),
    .o_cr_denom(den), .o_symbol_tick(tick), .o_header_present(hdr_present),
    .o_header_word(hdr_word));
  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic exp_err);
    host.xfer(wr, a, d, s, rd, er);
    if (host.timed_out) begin
      mismatches++;
      test_done();
    end
    chk("pslverr", {31'h0, exp_err}, {31'h0, er});
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [31:0] mword(input row_type r);
    return {19'h0, r.lro, 1'b0, r.cdr, r.bwc, r.spr};
  endfunction
  function automatic logic [31:0] sword(input row_type r);
    return {1'b0, r.khz, r.bwc == 4'h9, r.den, r.bits, r.chips};
  endfunction
  task automatic check_row(input row_type r);
    chk("chips", {20'h0, r.chips}, {20'h0, chips});
    chk("bits", {28'h0, r.bits}, {28'h0, bits});
    chk("bw_khz", {22'h0, r.khz}, {22'h0, bw_khz});
    chk("rate", {12'h0, r.rate}, {12'h0, sym_rate});
    chk("den", {28'h0, r.den}, {28'h0, den});
    chk("zero_if", {31'h0, r.bwc == 4'h9}, {31'h0, zero_if});
    chk("mix", {31'h0, r.bwc != 4'h9}, {31'h0, digital_mix});
  endtask
  initial begin
    rst_n = 1'b0;
    modem_run = 1'b0;
    mismatches = 0;
    checks_done = 0;
    rows = '{'{4'h7, 4'h7, 3'h1, 1'b0, 12'h080, 4'h7, 10'h07D, 20'h003D0, 4'h5},
             '{4'h5, 4'h9, 3'h1, 1'b0, 12'h020, 4'h5, 10'h1F4, 20'h03D09, 4'h5},
             '{4'h6, 4'h8, 3'h2, 1'b0, 12'h040, 4'h6, 10'h0FA, 20'h00F42, 4'h6},
             '{4'h7, 4'h7, 3'h3, 1'b0, 12'h080, 4'h7, 10'h07D, 20'h003D0, 4'h7},
             '{4'h8, 4'h9, 3'h4, 1'b1, 12'h100, 4'h6, 10'h1F4, 20'h007A1, 4'h8},
             '{4'h9, 4'h8, 3'h1, 1'b1, 12'h200, 4'h7, 10'h0FA, 20'h001E8, 4'h5},
             '{4'hA, 4'h7, 3'h2, 1'b1, 12'h400, 4'h8, 10'h07D, 20'h0007A, 4'h6},
             '{4'hB, 4'h7, 3'h4, 1'b1, 12'h800, 4'h9, 10'h07D, 20'h0003D, 4'h8}};
    bad = '{32'h0174, 32'h017C, 32'h0165, 32'h01A5, 32'h0075, 32'h0575};
    per = 32 * int'(ssm_cfg_pkg::CHIP_CYC_500);
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle();
    check_row(rows[0]);
    chk("fsk_en", 1, {31'h0, fsk_en});
    chk("hdr_present", 0, {31'h0, hdr_present});
    bus(1'b1, ssm_cfg_pkg::ADDR_MOD, mword(rows[1]), 4'hF, 1'b1);
    bus(1'b0, ssm_cfg_pkg::ADDR_FRAME, 0, 4'hF, 1'b0);
    chk("frame", 0, rd);
    settle();
    check_row(rows[0]);
    bus(1'b1, ssm_cfg_pkg::ADDR_FRAME, 1, 4'hF, 1'b0);
    bus(1'b0, ssm_cfg_pkg::ADDR_FRAME, 0, 4'hF, 1'b0);
    chk("frame", 1, rd);
    settle();
    chk("spread_en", 1, {31'h0, spread_en});
    chk("fsk_en", 0, {31'h0, fsk_en});
    $display("reset and frame kind test done");
    for (int i = 1; i < 8; i++) begin
      bus(1'b1, ssm_cfg_pkg::ADDR_MOD, mword(rows[i]), 4'hF, 1'b0);
      settle();
      check_row(rows[i]);
      bus(1'b0, ssm_cfg_pkg::ADDR_RATE, 0, 4'hF, 1'b0);
      chk("rate reg", {12'h0, rows[i].rate}, rd);
      bus(1'b0, ssm_cfg_pkg::ADDR_STAT, 0, 4'hF, 1'b0);
      chk("stat reg", sword(rows[i]), rd);
    end
    $display("parameter table test done");
    foreach (bad[i]) bus(1'b1, ssm_cfg_pkg::ADDR_MOD, bad[i], 4'hF, 1'b1);
    bus(1'b0, 12'h018, 0, 4'hF, 1'b1);
    chk("unmapped", 0, rd);
    bus(1'b1, ssm_cfg_pkg::ADDR_STAT, 32'hFFFF_FFFF, 4'hF, 1'b1);
    bus(1'b1, ssm_cfg_pkg::ADDR_FRAME, 2, 4'hF, 1'b1);
    settle();
    check_row(rows[7]);
    chk("spread_en", 1, {31'h0, spread_en});
    $display("refusal test done");
    bus(1'b1, ssm_cfg_pkg::ADDR_MOD, mword(rows[1]), 4'hF, 1'b0);
    bus(1'b1, ssm_cfg_pkg::ADDR_HDR, 32'h2A03, 4'hF, 1'b0);
    settle();
    chk("hdr_present", 1, {31'h0, hdr_present});
    chk("hdr_word", 32'h092A, {20'h0, hdr_word});
    bus(1'b1, ssm_cfg_pkg::ADDR_HDR, 0, 4'h1, 1'b0);
    settle();
    chk("hdr_present", 0, {31'h0, hdr_present});
    chk("hdr_word", 0, {20'h0, hdr_word});
    bus(1'b1, ssm_cfg_pkg::ADDR_HDR, 32'h5501, 4'h1, 1'b0);
    settle();
    chk("hdr_word", 32'h012A, {20'h0, hdr_word});
    bus(1'b0, ssm_cfg_pkg::ADDR_HWORD, 0, 4'hF, 1'b0);
    chk("hword reg", 32'h112A, rd);
    $display("header test done");
    @(posedge ref_clk);
    modem_run <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (tick !== 1'b1 && n < per + 8);
    if (tick !== 1'b1) begin
      mismatches++;
      test_done();
    end
    chk("first tick", 1, {31'h0, n >= per && n <= per + 2});
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (tick !== 1'b1 && n < per + 8);
    if (tick !== 1'b1) begin
      mismatches++;
      test_done();
    end
    chk("tick period", per, n);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    modem_run <= 1'b0;
    settle();
    check_row(rows[0]);
    chk("fsk_en", 1, {31'h0, fsk_en});
    bus(1'b0, ssm_cfg_pkg::ADDR_MOD, 0, 4'hF, 1'b0);
    chk("mod reset", 32'h0177, rd);
    $display("symbol timer and second reset test done");
    test_done();
  end
endmodule
`default_nettype wire
